//--- include/iosb_params.svh
// Offsets, address limits and reset values of the low I/O register space
// Functional notes
// R01 - Bit set and clear operations work on I/O addresses 0x00 to 0x1F only.
// R02 - Skip-test operations examine one bit of a bit-accessible register and report skip.
// R03 - Status flags clear when written with one; writing zero leaves them.
// R04 - Bit set or clear changes only the named bit, never other flags.
// R05 - Software writes zero to reserved bits.
// R06 - Software never writes reserved I/O addresses.
// R07 - Each I/O register also appears in data space at its address plus 0x20.
`ifndef IOSB_PARAMS_SVH
`define IOSB_PARAMS_SVH

`define IOSB_OFS_GP_SCRATCH_0      6'h0a
`define IOSB_OFS_GP_SCRATCH_1      6'h0b
`define IOSB_OFS_GP_SCRATCH_2      6'h0c
`define IOSB_OFS_EVENT_FLAGS       6'h0d
`define IOSB_OFS_PORT_B_INPUT      6'h16
`define IOSB_OFS_PORT_B_DIRECTION  6'h17
`define IOSB_OFS_PORT_B_OUTPUT     6'h18
`define IOSB_OFS_PORT_A_INPUT      6'h19
`define IOSB_OFS_PORT_A_DIRECTION  6'h1a
`define IOSB_OFS_PORT_A_OUTPUT     6'h1b

`define IOSB_BIT_OP_LAST           8'h1f
`define IOSB_IO_LAST               8'h3f
`define IOSB_DATA_BASE             8'h20
`define IOSB_DATA_LAST             8'h5f

`define IOSB_RESET_BYTE            8'h00
`define IOSB_READ_UNMAPPED         8'h00

`endif

//--- include/iosb_pkg.sv
// Types shared by the I/O space register bank
`default_nettype none
package iosb_pkg;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_IO_READ,
		OP_IO_WRITE,
		OP_DATA_READ,
		OP_DATA_WRITE,
		OP_SET_BIT,
		OP_CLEAR_BIT,
		OP_SKIP_IF_SET,
		OP_SKIP_IF_CLEAR
	} iosb_op_type;

	typedef struct packed {
		logic [7:0] gpScratch0;
		logic [7:0] gpScratch1;
		logic [7:0] gpScratch2;
		logic [7:0] portADir;
		logic [7:0] portAOut;
		logic [7:0] portBDir;
		logic [7:0] portBOut;
		logic [7:0] pinASync1;
		logic [7:0] pinASync2;
		logic [7:0] pinBSync1;
		logic [7:0] pinBSync2;
		logic [7:0] rdData;
		logic       ack;
		logic       skipNext;
		logic       refused;
	} iosb_state_type;

	typedef struct packed {
		logic [7:0] flags;
	} iosb_flag_state_type;

endpackage : iosb_pkg
`default_nettype wire

//--- rtl/iosb_flag_reg.sv
// Write-one-to-clear status flag register with hardware set priority
`timescale 1ns/1ps
`default_nettype none
`include "iosb_params.svh"

module iosb_flag_reg (
	input  wire logic       clk_sys,   // System clock
	input  wire logic       srst,      // Synchronous reset, active high
	input  wire logic [7:0] setEvt,    // Hardware event pulses, one per flag
	input  wire logic [7:0] clrMask,   // Ones clear the matching flags
	output logic      [7:0] flags      // Current flag levels
);

	iosb_pkg::iosb_flag_state_type st_r;
	iosb_pkg::iosb_flag_state_type st_nxt;

	// Event in the clearing cycle must survive, so set wins
	always_comb begin
		st_nxt = st_r;
		for (int i = 0; i < 8; i++) begin
			st_nxt.flags[i] = setEvt[i] | (st_r.flags[i] & ~clrMask[i]); // see R03
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_r.flags <= `IOSB_RESET_BYTE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flags = st_r.flags;

endmodule : iosb_flag_reg
`default_nettype wire

//--- rtl/iosb_io_space.sv
// Low I/O register space with byte access, data-space mirror and bit operations
`timescale 1ns/1ps
`default_nettype none
`include "iosb_params.svh"

module iosb_io_space (
	input  wire logic       clk_sys,    // System clock, 200 MHz
	input  wire logic       srst,       // Synchronous reset, active high
	input  wire logic       reqValid,   // Request strobe from the core
	input  wire logic [3:0] reqOp,      // Operation, iosb_op_type encoding
	input  wire logic [7:0] reqAddr,    // I/O address or data-space address
	input  wire logic [2:0] reqBit,     // Bit number for bit operations
	input  wire logic [7:0] reqWdata,   // Write byte
	input  wire logic [7:0] port_a_input_level,       // Port A pin levels, asynchronous
	input  wire logic [7:0] port_b_input_level,       // Port B pin levels, asynchronous
	input  wire logic [7:0] evtFlags,   // Peripheral event pulses to flags
	output logic      [7:0] rdData,     // Read byte, registered
	output logic            ack,        // Request done, one-cycle pulse
	output logic            skipNext,   // Skip the next instruction, pulse
	output logic            refused,    // Request out of range, pulse
	output logic      [7:0] portAOut,   // Port A output values
	output logic      [7:0] portADir,   // Port A directions, one drives
	output logic      [7:0] portBOut,   // Port B output values
	output logic      [7:0] portBDir,   // Port B directions, one drives
	output logic      [7:0] eventFlags  // Sticky event flags
);

	iosb_pkg::iosb_state_type st_r;
	iosb_pkg::iosb_state_type st_nxt;

	logic [7:0] flagVal;
	logic [7:0] flagClr;

	iosb_flag_reg iosb_flag_reg_inst (
		.clk_sys (clk_sys),
		.srst    (srst),
		.setEvt  (evtFlags),
		.clrMask (flagClr),
		.flags   (flagVal)
	);

	function automatic logic [7:0] read_reg(
		input logic [5:0]                idx,
		input iosb_pkg::iosb_state_type  s,
		input logic [7:0]                fl
	);
		logic [7:0] v;
		v = `IOSB_READ_UNMAPPED;
		case (idx)
			`IOSB_OFS_GP_SCRATCH_0:     v = s.gpScratch0;
			`IOSB_OFS_GP_SCRATCH_1:     v = s.gpScratch1;
			`IOSB_OFS_GP_SCRATCH_2:     v = s.gpScratch2;
			`IOSB_OFS_EVENT_FLAGS:      v = fl;
			`IOSB_OFS_PORT_B_INPUT:     v = s.pinBSync2;
			`IOSB_OFS_PORT_B_DIRECTION: v = s.portBDir;
			`IOSB_OFS_PORT_B_OUTPUT:    v = s.portBOut;
			`IOSB_OFS_PORT_A_INPUT:     v = s.pinASync2;
			`IOSB_OFS_PORT_A_DIRECTION: v = s.portADir;
			`IOSB_OFS_PORT_A_OUTPUT:    v = s.portAOut;
			default:                    v = `IOSB_READ_UNMAPPED;
		endcase
		return v;
	endfunction : read_reg

	iosb_pkg::iosb_op_type op;
	logic [5:0] idx;
	logic [7:0] dataOfs;
	logic       inRange;
	logic       isBitOp;
	logic       doWrite;
	logic       doRead;
	logic [7:0] curVal;
	logic [7:0] bitMask;
	logic [7:0] wrVal;
	logic [7:0] w1cMask;
	logic       flagHit;

	always_comb begin
		op      = iosb_pkg::iosb_op_type'(reqOp);
		dataOfs = reqAddr - `IOSB_DATA_BASE;
		isBitOp = 1'b0;
		doWrite = 1'b0;
		doRead  = 1'b0;
		inRange = 1'b0;
		idx     = reqAddr[5:0];
		case (op)
			// Idle cycles decode as out of range but never raise ack
			iosb_pkg::OP_NONE: begin
				inRange = 1'b0;
			end
			iosb_pkg::OP_IO_READ: begin
				inRange = (reqAddr <= `IOSB_IO_LAST);
				doRead  = 1'b1;
			end
			iosb_pkg::OP_IO_WRITE: begin
				inRange = (reqAddr <= `IOSB_IO_LAST);
				doWrite = 1'b1;
			end
			// Data-space view is the same register at address minus 0x20
			iosb_pkg::OP_DATA_READ: begin
				inRange = (reqAddr >= `IOSB_DATA_BASE) && (reqAddr <= `IOSB_DATA_LAST); // see R07
				idx     = dataOfs[5:0];
				doRead  = 1'b1;
			end
			iosb_pkg::OP_DATA_WRITE: begin
				inRange = (reqAddr >= `IOSB_DATA_BASE) && (reqAddr <= `IOSB_DATA_LAST); // see R07
				idx     = dataOfs[5:0];
				doWrite = 1'b1;
			end
			iosb_pkg::OP_SET_BIT, iosb_pkg::OP_CLEAR_BIT: begin
				isBitOp = 1'b1;
				inRange = (reqAddr <= `IOSB_BIT_OP_LAST); // see R01
				doWrite = 1'b1;
			end
			iosb_pkg::OP_SKIP_IF_SET, iosb_pkg::OP_SKIP_IF_CLEAR: begin
				isBitOp = 1'b1;
				inRange = (reqAddr <= `IOSB_BIT_OP_LAST); // see R01
			end
			default: begin
				inRange = 1'b0;
			end
		endcase
	end

	always_comb begin
		curVal  = read_reg(idx, st_r, flagVal);
		bitMask = 8'h01 << reqBit;
		wrVal   = reqWdata;
		w1cMask = reqWdata;
		if (op == iosb_pkg::OP_SET_BIT) begin
			wrVal   = curVal | bitMask;   // see R04
			w1cMask = bitMask;            // see R04
		end else if (op == iosb_pkg::OP_CLEAR_BIT) begin
			wrVal   = curVal & ~bitMask;  // see R04
			w1cMask = 8'h00;              // see R04
		end
	end

	// Flags take only the ones written, never the read-modify-write image
	assign flagHit = reqValid && inRange && doWrite && (idx == `IOSB_OFS_EVENT_FLAGS);
	assign flagClr = flagHit ? w1cMask : 8'h00; // see R03

	always_comb begin
		st_nxt          = st_r;
		st_nxt.ack      = 1'b0;
		st_nxt.skipNext = 1'b0;
		st_nxt.refused  = 1'b0;
		// Pin levels cross in through two flops before any read
		st_nxt.pinASync1 = port_a_input_level;
		st_nxt.pinASync2 = st_r.pinASync1;
		st_nxt.pinBSync1 = port_b_input_level;
		st_nxt.pinBSync2 = st_r.pinBSync1;
		if (reqValid && op != iosb_pkg::OP_NONE) begin
			st_nxt.ack = 1'b1;
			if (!inRange) begin
				st_nxt.refused = 1'b1; // see R01
			end else begin
				if (doRead) begin
					st_nxt.rdData = curVal;
				end
				// Skip tests see the byte before any same-cycle change
				if (op == iosb_pkg::OP_SKIP_IF_SET) begin
					st_nxt.skipNext = curVal[reqBit]; // see R02
				end
				if (op == iosb_pkg::OP_SKIP_IF_CLEAR) begin
					st_nxt.skipNext = ~curVal[reqBit]; // see R02
				end
				// Input-level and unmapped addresses swallow writes
				if (doWrite) begin
					case (idx)
						`IOSB_OFS_GP_SCRATCH_0:     st_nxt.gpScratch0 = wrVal;
						`IOSB_OFS_GP_SCRATCH_1:     st_nxt.gpScratch1 = wrVal;
						`IOSB_OFS_GP_SCRATCH_2:     st_nxt.gpScratch2 = wrVal;
						`IOSB_OFS_PORT_B_DIRECTION: st_nxt.portBDir   = wrVal;
						`IOSB_OFS_PORT_B_OUTPUT:    st_nxt.portBOut   = wrVal;
						`IOSB_OFS_PORT_A_DIRECTION: st_nxt.portADir   = wrVal;
						`IOSB_OFS_PORT_A_OUTPUT:    st_nxt.portAOut   = wrVal;
						// Input levels and flags are not stored in this state
						`IOSB_OFS_PORT_B_INPUT, `IOSB_OFS_PORT_A_INPUT,
						`IOSB_OFS_EVENT_FLAGS: begin
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_r.gpScratch0 <= `IOSB_RESET_BYTE;
			st_r.gpScratch1 <= `IOSB_RESET_BYTE;
			st_r.gpScratch2 <= `IOSB_RESET_BYTE;
			st_r.portADir   <= `IOSB_RESET_BYTE;
			st_r.portAOut   <= `IOSB_RESET_BYTE;
			st_r.portBDir   <= `IOSB_RESET_BYTE;
			st_r.portBOut   <= `IOSB_RESET_BYTE;
			st_r.pinASync1  <= `IOSB_RESET_BYTE;
			st_r.pinASync2  <= `IOSB_RESET_BYTE;
			st_r.pinBSync1  <= `IOSB_RESET_BYTE;
			st_r.pinBSync2  <= `IOSB_RESET_BYTE;
			st_r.rdData     <= `IOSB_RESET_BYTE;
			st_r.ack        <= 1'b0;
			st_r.skipNext   <= 1'b0;
			st_r.refused    <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdData     = st_r.rdData;
	assign ack        = st_r.ack;
	assign skipNext   = st_r.skipNext;
	assign refused    = st_r.refused;
	assign portAOut   = st_r.portAOut;
	assign portADir   = st_r.portADir;
	assign portBOut   = st_r.portBOut;
	assign portBDir   = st_r.portBDir;
	assign eventFlags = flagVal;

endmodule : iosb_io_space
`default_nettype wire

//--- bench/iosb_io_space_monitor.sv
// Checker for the I/O space register bank
`timescale 1ns/1ps
`default_nettype none
module iosb_io_space_monitor (
	input wire logic       clk_sys,   // Clock
	input wire logic       srst,      // Reset
	input wire logic       reqValid,  // Strobe
	input wire logic [3:0] reqOp,     // Operation
	input wire logic [7:0] reqAddr,   // Address
	input wire logic [2:0] reqBit,    // Bit number
	input wire logic [7:0] reqWdata,  // Write byte
	input wire logic [7:0] evtFlags,  // Event pulses
	input wire logic       ack,       // Done
	input wire logic       skipNext,  // Skip result
	input wire logic       refused,   // Refusal
	input wire logic [7:0] portBOut,  // Port B outputs
	input wire logic [7:0] eventFlags // Flags
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	logic bitVal_r;
	always_ff @(posedge clk_sys) begin
		bitVal_r <= portBOut[reqBit];
	end
	chk_bitop_range: assert property (reqValid && reqOp inside {4'h5, 4'h6}
		&& reqAddr > 8'h1f |=> ack && refused) else $error("bit op not refused");
	chk_skip_set: assert property (reqValid && reqOp == 4'h7 && reqAddr == 8'h18
		|=> ack && skipNext == bitVal_r) else $error("skip if set wrong");
	chk_skip_clear: assert property (reqValid && reqOp == 4'h8 && reqAddr == 8'h18
		|=> skipNext != bitVal_r) else $error("skip if clear wrong");
	chk_flag_w1c: assert property (reqValid && reqOp == 4'h2 && reqAddr == 8'h0d
		&& evtFlags == 8'h00 |=> eventFlags == ($past(eventFlags) & ~$past(reqWdata)))
		else $error("flag write wrong");
	chk_single_bit: assert property (reqValid && reqOp == 4'h5 && reqAddr == 8'h18
		|=> portBOut == ($past(portBOut) | (8'h01 << $past(reqBit)))) else $error("set bit wrong");
	chk_flag_bit: assert property (reqValid && reqOp == 4'h5 && reqAddr == 8'h0d
		&& evtFlags == 8'h00 |=> eventFlags == ($past(eventFlags) & ~(8'h01 << $past(reqBit))))
		else $error("flag bit clear wrong");
	chk_data_mirror: assert property (reqValid && reqOp == 4'h4 && reqAddr == 8'h38
		|=> portBOut == $past(reqWdata)) else $error("mirror write wrong");
endmodule : iosb_io_space_monitor
bind iosb_io_space iosb_io_space_monitor iosb_io_space_monitor_inst (.clk_sys, .srst,
	.reqValid, .reqOp, .reqAddr, .reqBit, .reqWdata, .evtFlags, .ack, .skipNext, .refused,
	.portBOut, .eventFlags);
`default_nettype wire

//--- bench/iosb_core_model.sv
// Behavioural core issuing register and bit requests
`timescale 1ns/1ps
`default_nettype none
module iosb_core_model (
	input  wire logic       clk_sys,  // Clock
	input  wire logic       ack,      // Done
	input  wire logic [7:0] rdData,   // Read byte
	input  wire logic       skipNext, // Skip result
	input  wire logic       refused,  // Refusal
	output logic            reqValid, // Strobe
	output logic      [3:0] reqOp,    // Operation
	output logic      [7:0] reqAddr,  // Address
	output logic      [2:0] reqBit,   // Bit number
	output logic      [7:0] reqWdata  // Write byte
);
	initial begin
		reqValid = 1'b0;
		reqOp = 4'h0;
		reqAddr = 8'h00;
		reqBit = 3'h0;
		reqWdata = 8'h00;
	end
	// Callers also reach unmapped 0x1f and out-of-range 0x20, 0x40 and 0x60, and send reserved bits as zero
	task automatic xfer(input logic [3:0] o, input logic [7:0] a, input logic [2:0] b,
		input logic [7:0] w, output logic [7:0] r, output logic s, output logic f,
		output logic k);
		@(posedge clk_sys);
		reqValid <= 1'b1;
		reqOp <= o;
		reqAddr <= a;
		reqBit <= b;
		reqWdata <= w;
		@(posedge clk_sys);
		reqValid <= 1'b0;
		reqAddr <= ~a;
		reqWdata <= ~w;
		#1;
		r = rdData;
		s = skipNext;
		f = refused;
		k = ack;
	endtask : xfer
endmodule : iosb_core_model
`default_nettype wire

//--- bench/iosb_io_space_tb.sv
// Self-checking bench for the I/O space register bank
`timescale 1ns/1ps
`default_nettype none
module iosb_io_space_tb;
	logic       clk_sys, srst, reqValid, ack, skipNext, refused, sk, rf, ak;
	logic [3:0] reqOp;
	logic [2:0] reqBit;
	logic [7:0] reqAddr, reqWdata, port_a_input_level, port_b_input_level, evtFlags, rdData, rd;
	logic [7:0] portAOut, portADir, portBOut, portBDir, eventFlags;
	int         errCount = 0;
	int         numChecks = 0;
	iosb_io_space iosb_io_space_inst (.clk_sys, .srst, .reqValid, .reqOp, .reqAddr, .reqBit,
		.reqWdata, .port_a_input_level, .port_b_input_level, .evtFlags, .rdData, .ack, .skipNext, .refused, .portAOut,
		.portADir, .portBOut, .portBDir, .eventFlags);
	iosb_core_model iosb_core_model_inst (.clk_sys, .ack, .rdData, .skipNext, .refused,
		.reqValid, .reqOp, .reqAddr, .reqBit, .reqWdata);
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		numChecks++;
		if (s !== e) begin
			errCount++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic go(logic [3:0] o, logic [7:0] a, logic [2:0] b, logic [7:0] w);
		iosb_core_model_inst.xfer(o, a, b, w, rd, sk, rf, ak);
	endtask : go
	task automatic printVerdict();
		if (errCount == 0 && numChecks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : printVerdict
	initial begin
		srst = 1'b1;
		port_a_input_level = 8'h00;
		port_b_input_level = 8'h00;
		evtFlags = 8'h00;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		go(4'h1, 8'h18, 3'h0, 8'h00);
		chk("reset", rd, 8'h00);
		go(4'h4, 8'h38, 3'h0, 8'ha5);
		go(4'h1, 8'h18, 3'h0, 8'h00);
		chk("mirror", rd, 8'ha5);
		go(4'h5, 8'h18, 3'h1, 8'h00);
		go(4'h6, 8'h18, 3'h0, 8'h00);
		chk("bit ops", portBOut, 8'ha6);
		go(4'h7, 8'h18, 3'h1, 8'h00);
		chk("skip set", {7'h0, sk}, 8'h01);
		go(4'h8, 8'h18, 3'h1, 8'h00);
		chk("skip clear", {7'h0, sk}, 8'h00);
		go(4'h8, 8'h18, 3'h0, 8'h00);
		chk("skip clear 0", {7'h0, sk}, 8'h01);
		go(4'h5, 8'h20, 3'h0, 8'h00);
		chk("refuse 20", {6'h0, ak, rf}, 8'h03);
		go(4'h5, 8'h1f, 3'h0, 8'h00);
		chk("accept 1f", {6'h0, ak, rf}, 8'h02);
		go(4'h1, 8'h40, 3'h0, 8'h00);
		chk("refuse io 40", {6'h0, ak, rf}, 8'h03);
		go(4'h4, 8'h60, 3'h0, 8'h00);
		chk("refuse data 60", {6'h0, ak, rf}, 8'h03);
		for (int i = 0; i < 3; i++) begin
			go(4'h4, 8'h2a + 8'(i), 3'h0, 8'h5a ^ 8'(i));
			go(4'h1, 8'h0a + 8'(i), 3'h0, 8'h00);
			chk("scratch", rd, 8'h5a ^ 8'(i));
		end
		go(4'h2, 8'h1a, 3'h0, 8'h0f);
		chk("port a dir", portADir, 8'h0f);
		go(4'h4, 8'h3b, 3'h0, 8'hf0);
		chk("port a out", portAOut, 8'hf0);
		go(4'h2, 8'h17, 3'h0, 8'h33);
		chk("port b dir", portBDir, 8'h33);
		@(posedge clk_sys);
		evtFlags <= 8'h0f;
		@(posedge clk_sys);
		evtFlags <= 8'h00;
		go(4'h2, 8'h0d, 3'h0, 8'h01);
		chk("w1c", eventFlags, 8'h0e);
		go(4'h2, 8'h0d, 3'h0, 8'h00);
		chk("w0", eventFlags, 8'h0e);
		go(4'h5, 8'h0d, 3'h2, 8'h00);
		chk("flag set", eventFlags, 8'h0a);
		go(4'h6, 8'h0d, 3'h1, 8'h00);
		chk("flag clr", eventFlags, 8'h0a);
		go(4'h8, 8'h0d, 3'h2, 8'h00);
		chk("flag skip", {7'h0, sk}, 8'h01);
		fork
			go(4'h2, 8'h0d, 3'h0, 8'h0b);
			begin
				@(posedge clk_sys);
				evtFlags <= 8'h01;
				@(posedge clk_sys);
				evtFlags <= 8'h00;
			end
		join
		chk("set wins", eventFlags, 8'h01);
		@(posedge clk_sys);
		port_a_input_level <= 8'h3c;
		port_b_input_level <= 8'hc3;
		repeat (3) @(posedge clk_sys);
		go(4'h2, 8'h19, 3'h0, 8'hff);
		go(4'h1, 8'h19, 3'h0, 8'h00);
		chk("pin a", rd, 8'h3c);
		go(4'h3, 8'h36, 3'h0, 8'h00);
		chk("pin b", rd, 8'hc3);
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		go(4'h1, 8'h1b, 3'h0, 8'h00);
		chk("reset rd", rd, 8'h00);
		chk("reset flags", eventFlags, 8'h00);
		chk("reset ports", portBOut | portBDir | portAOut | portADir, 8'h00);
		printVerdict();
	end
	initial begin
		#100000;
		errCount++;
		printVerdict();
	end
endmodule : iosb_io_space_tb
`default_nettype wire
